// [hdl/spd_pkg.sv]
package spd_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_LOW_MIN_NS = 1300;
	// Quarter of a serial bit; two quarters form the low phase
	localparam int QTR_CYCLES =
		(SCL_LOW_MIN_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int PROG_TIME_MS = 10;
	localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// ****************************************
	// Link framing
	// ****************************************
	localparam logic [3:0] SEL_MEMORY = 4'hA;
	localparam int PAGE_BYTES = 16;
	localparam int TABLE_BYTES = 256;

	// ****************************************
	// Table locations
	// ****************************************
	localparam logic [7:0] LOC_BYTES_IN_USE      = 8'h00;
	localparam logic [7:0] LOC_TOTAL_TABLE_SIZE  = 8'h01;
	localparam logic [7:0] LOC_MEMORY_KIND       = 8'h02;
	localparam logic [7:0] LOC_ROW_ADDRESS_COUNT = 8'h03;
	localparam logic [7:0] LOC_COLUMN_ADDR_COUNT = 8'h04;
	localparam logic [7:0] LOC_RANK_COUNT        = 8'h05;
	localparam logic [7:0] LOC_DATA_WIDTH_LOW    = 8'h06;
	localparam logic [7:0] LOC_DATA_WIDTH_HIGH   = 8'h07;
	localparam logic [7:0] LOC_INTERFACE_LEVEL   = 8'h08;
	localparam logic [7:0] LOC_CYCLE_TIME_LAT3   = 8'h09;
	localparam logic [7:0] LOC_ACCESS_TIME_LAT3  = 8'h0A;
	localparam logic [7:0] LOC_CONFIG_KIND       = 8'h0B;
	localparam logic [7:0] LOC_REFRESH_RATE_KIND = 8'h0C;
	localparam logic [7:0] LOC_PRIMARY_WIDTH     = 8'h0D;
	localparam logic [7:0] LOC_CHECK_WIDTH       = 8'h0E;
	localparam logic [7:0] LOC_COL_TO_COL_DELAY  = 8'h0F;
	localparam logic [7:0] LOC_BURST_LENGTHS     = 8'h10;
	localparam logic [7:0] LOC_BANK_COUNT        = 8'h11;

	// ****************************************
	// Host controller registers
	// ****************************************
	localparam logic [7:0] CMD_OFS  = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] WCTL_OFS = 8'h08;
	localparam int CMD_OP_LSB    = 0;
	localparam int CMD_ACK_BIT   = 2;
	localparam int CMD_DATA_LSB  = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NACK_BIT = 1;
	localparam int STAT_DATA_LSB = 8;
	localparam logic WCTL_RESET  = 1'b1;

	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_STOP  = 2'b01,
		OP_WRITE = 2'b10,
		OP_READ  = 2'b11
	} op_e;

	// ****************************************
	// Table contents after reset
	// ****************************************
	function automatic logic [7:0] table_reset(input logic [7:0] loc,
		input int density, input int grade);
		logic [7:0] v;
		v = 8'h00;
		case (loc)
			LOC_BYTES_IN_USE:      v = 8'h80;
			LOC_TOTAL_TABLE_SIZE:  v = 8'h08;
			LOC_MEMORY_KIND:       v = 8'h04;
			LOC_ROW_ADDRESS_COUNT: v = (density == 2) ? 8'h0D : 8'h0C;
			LOC_COLUMN_ADDR_COUNT: v = (density == 0) ? 8'h08 : 8'h09;
			LOC_RANK_COUNT:        v = 8'h02;
			LOC_DATA_WIDTH_LOW:    v = 8'h40;
			LOC_DATA_WIDTH_HIGH:   v = 8'h00;
			LOC_INTERFACE_LEVEL:   v = 8'h01;
			LOC_CYCLE_TIME_LAT3:   v = (grade == 0) ? 8'h70 :
				((grade == 1) ? 8'h75 : 8'h80);
			LOC_ACCESS_TIME_LAT3:  v = (grade == 2) ? 8'h60 : 8'h54;
			LOC_CONFIG_KIND:       v = 8'h00;
			LOC_REFRESH_RATE_KIND: v = (density == 2) ? 8'h82 : 8'h80;
			LOC_PRIMARY_WIDTH:     v = 8'h10;
			LOC_CHECK_WIDTH:       v = 8'h00;
			LOC_COL_TO_COL_DELAY:  v = 8'h01;
			LOC_BURST_LENGTHS:     v = 8'h8F;
			LOC_BANK_COUNT:        v = 8'h04;
			default:               v = 8'h00;
		endcase
		return v;
	endfunction

endpackage

// [hdl/spd_link_if.sv]
interface spd_link_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic write_inhibit_input;
	logic scl;
	logic sda;

	// ****************************************
	// Wired-AND with pull-ups
	// ****************************************
	assign scl = ~(~host_scl_oe_n & ~host_scl_o);
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) |
		(~dev_sda_oe_n & ~dev_sda_o));

	modport dev (
		input  scl,
		input  sda,
		input  write_inhibit_input,
		output dev_sda_o,
		output dev_sda_oe_n
	);

	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n,
		output write_inhibit_input
	);
endinterface

// [hdl/spd_host_ctrl.sv]
module spd_host_ctrl #(
	parameter int QTR = spd_pkg::QTR_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	spd_link_if.host         link
);
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_STOP  = 2'b10,
		H_BITS  = 2'b11
	} hstate_e;
	localparam int DW = $clog2(QTR + 1);

	hstate_e     state_q, state_d;
	logic [1:0]  q_q, q_d;
	logic [3:0]  bit_q, bit_d;
	logic [8:0]  tx_q, tx_d;
	logic [8:0]  rx_q, rx_d;
	logic        scl_oe_n_q, scl_oe_n_d;
	logic        sda_oe_n_q, sda_oe_n_d;
	logic        wctl_q, wctl_d;
	logic [DW-1:0] div_q, div_d;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        pready_d;
	logic        pslverr_d;
	logic        sda_m_q, sda_s_q;
	logic        tick;
	logic        setup;
	logic        wr_acc;

	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe_n = scl_oe_n_q;
	assign link.host_sda_oe_n = sda_oe_n_q;
	assign link.write_inhibit_input = wctl_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	assign tick = (div_q == DW'(QTR - 1));
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready_q & pwrite;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		q_d = q_q;
		bit_d = bit_q;
		tx_d = tx_q;
		rx_d = rx_q;
		scl_oe_n_d = scl_oe_n_q;
		sda_oe_n_d = sda_oe_n_q;
		wctl_d = wctl_q;
		div_d = tick ? '0 : div_q + DW'(1);
		pready_d = setup;
		pslverr_d = setup & (paddr != spd_pkg::CMD_OFS) &
			(paddr != spd_pkg::STAT_OFS) & (paddr != spd_pkg::WCTL_OFS);
		prdata_d = 32'h0000_0000;
		if (setup && paddr == spd_pkg::STAT_OFS) begin
			prdata_d[spd_pkg::STAT_DATA_LSB +: 8] = rx_q[8:1];
			prdata_d[spd_pkg::STAT_NACK_BIT] = rx_q[0];
			prdata_d[spd_pkg::STAT_BUSY_BIT] = (state_q != H_IDLE);
		end else if (setup && paddr == spd_pkg::WCTL_OFS) begin
			prdata_d[0] = wctl_q;
		end
		if (wr_acc && paddr == spd_pkg::WCTL_OFS) begin
			wctl_d = pwdata[0];
		end
		// Commands while busy are dropped; software polls busy first
		if (wr_acc && paddr == spd_pkg::CMD_OFS && state_q == H_IDLE) begin
			q_d = 2'b00;
			div_d = '0;
			bit_d = 4'h0;
			case (spd_pkg::op_e'(pwdata[spd_pkg::CMD_OP_LSB +: 2]))
				spd_pkg::OP_START: state_d = H_START;
				spd_pkg::OP_STOP:  state_d = H_STOP;
				spd_pkg::OP_WRITE: begin
					state_d = H_BITS;
					tx_d = {pwdata[spd_pkg::CMD_DATA_LSB +: 8], 1'b1};
				end
				default: begin
					state_d = H_BITS;
					tx_d = {8'hFF, ~pwdata[spd_pkg::CMD_ACK_BIT]};
				end
			endcase
		end else if (tick && state_q != H_IDLE) begin
			q_d = q_q + 2'd1;
			case (state_q)
				H_START: begin
					// Works from idle and as a repeated start
					case (q_q)
						2'd0: sda_oe_n_d = 1'b1;
						2'd1: scl_oe_n_d = 1'b1;
						2'd2: sda_oe_n_d = 1'b0;
						default: begin
							scl_oe_n_d = 1'b0;
							state_d = H_IDLE;
						end
					endcase
				end
				H_STOP: begin
					case (q_q)
						2'd0: sda_oe_n_d = 1'b0;
						2'd1: scl_oe_n_d = 1'b1;
						2'd2: sda_oe_n_d = 1'b1;
						default: state_d = H_IDLE;
					endcase
				end
				H_BITS: begin
					case (q_q)
						2'd0: sda_oe_n_d = tx_q[8];
						2'd1: scl_oe_n_d = 1'b1;
						2'd2: scl_oe_n_d = 1'b1;
						default: begin
							rx_d = {rx_q[7:0], sda_s_q};
							tx_d = {tx_q[7:0], 1'b1};
							scl_oe_n_d = 1'b0;
							bit_d = bit_q + 4'd1;
							if (bit_q == 4'd8) begin
								state_d = H_IDLE;
							end
						end
					endcase
				end
				default: state_d = H_IDLE;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= H_IDLE;
			q_q <= 2'b00;
			bit_q <= 4'h0;
			tx_q <= 9'h1FF;
			rx_q <= 9'h000;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			wctl_q <= spd_pkg::WCTL_RESET;
			div_q <= '0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			state_q <= state_d;
			q_q <= q_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			scl_oe_n_q <= scl_oe_n_d;
			sda_oe_n_q <= sda_oe_n_d;
			wctl_q <= wctl_d;
			div_q <= div_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			sda_m_q <= link.sda;
			sda_s_q <= sda_m_q;
		end
	end
endmodule

// [hdl/spd_eeprom_dev.sv]
// Contract
// - Select with read bit returns pointer byte
// - Select with write bit plus address loads pointer
// - Repeated start then read returns that byte
// - Reading continues while host acknowledges
// - Writes are one byte or up to sixteen
// - Silent program cycle after write stop
// - Locations 0 and 1: usage and size
// - Location 2 kind, location 3 rows
// - Location 4 columns, location 5 ranks
// - Locations 6 and 7: data width
// - Location 8 interface, location 11 config
// - Locations 9 and 10: speed bytes
// - Locations 12 to 14: refresh, widths
// - Location 15: column to column delay
// - Location 16 bursts, location 17 banks
// - Acknowledge select and write bytes; stop on nack
// - Select byte is 1010, slot pins, direction
// - Start wakes device, stop returns to standby
module spd_eeprom_dev #(
	parameter int DENSITY     = 2,
	parameter int SPEED_GRADE = 1,
	parameter int PROG_CYCLES = spd_pkg::PROG_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	spd_link_if.dev   link,
	input  wire logic module_slot_pin_0,
	input  wire logic module_slot_pin_1,
	input  wire logic module_slot_pin_2,
	output logic      prog_busy
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_RACK = 3'b100,
		ST_PROG = 3'b101
	} state_e;

	typedef enum logic [1:0] {
		PH_SEL  = 2'b00,
		PH_WORD = 2'b01,
		PH_DATA = 2'b10
	} phase_e;

	localparam int PW = $clog2(PROG_CYCLES + 1);

	state_e      state_q, state_d;
	phase_e      phase_q, phase_d;
	logic        rw_q, rw_d;
	logic [3:0]  bitcnt_q, bitcnt_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  ptr_q, ptr_d;
	logic [4:0]  wcount_q, wcount_d;
	logic        wrote_q, wrote_d;
	logic        oe_n_q, oe_n_d;
	logic        busy_q, busy_d;
	logic [PW-1:0] prog_cnt_q, prog_cnt_d;
	logic [7:0]  mem_q [spd_pkg::TABLE_BYTES];
	logic [7:0]  mem_d [spd_pkg::TABLE_BYTES];
	logic [5:0]  sync_m_q;
	logic [5:0]  sync_s_q;
	logic        scl_prev_q;
	logic        sda_prev_q;
	logic        scl_s;
	logic        sda_s;
	logic        inhibit;
	logic [2:0]  slot;
	logic        start_det;
	logic        stop_det;
	logic        scl_rise;
	logic        scl_fall;

	assign scl_s = sync_s_q[5];
	assign sda_s = sync_s_q[4];
	assign inhibit = sync_s_q[3];
	assign slot = sync_s_q[2:0];
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;

	// Open-drain: only the enable moves
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe_n = oe_n_q;
	assign prog_busy = busy_q;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		rw_d = rw_q;
		bitcnt_d = bitcnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		wcount_d = wcount_q;
		wrote_d = wrote_q;
		oe_n_d = oe_n_q;
		prog_cnt_d = prog_cnt_q;
		mem_d = mem_q;
		if (state_q == ST_PROG) begin
			// Bus ignored entirely, so own select goes unanswered
			if (prog_cnt_q == PW'(PROG_CYCLES - 1)) begin
				state_d = ST_IDLE;
				prog_cnt_d = '0;
			end else begin
				prog_cnt_d = prog_cnt_q + PW'(1);
			end
		end else if (stop_det) begin
			oe_n_d = 1'b1;
			wcount_d = 5'd0;
			wrote_d = 1'b0;
			state_d = wrote_q ? ST_PROG : ST_IDLE;
		end else if (start_det) begin
			state_d = ST_RX;
			phase_d = PH_SEL;
			bitcnt_d = 4'h0;
			oe_n_d = 1'b1;
		end else begin
			case (state_q)
				ST_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						bitcnt_d = bitcnt_q + 4'd1;
					end else if (scl_fall && bitcnt_q == 4'd8) begin
						state_d = ST_ACK;
						oe_n_d = 1'b0;
						case (phase_q)
							PH_SEL: begin
								rw_d = sh_q[0];
								if (sh_q[7:1] != {spd_pkg::SEL_MEMORY, slot}) begin
									state_d = ST_IDLE;
									oe_n_d = 1'b1;
								end
							end
							PH_WORD: ptr_d = sh_q;
							default: begin
								if (inhibit ||
									wcount_q == 5'(spd_pkg::PAGE_BYTES)) begin
									state_d = ST_IDLE;
									oe_n_d = 1'b1;
								end else begin
									mem_d[ptr_q] = sh_q;
									ptr_d = ptr_q + 8'd1;
									wcount_d = wcount_q + 5'd1;
									wrote_d = 1'b1;
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bitcnt_d = 4'h0;
						if (phase_q == PH_SEL && rw_q) begin
							// Current or random read starts here
							sh_d = mem_q[ptr_q];
							oe_n_d = mem_q[ptr_q][7];
							ptr_d = ptr_q + 8'd1;
							state_d = ST_TX;
						end else begin
							oe_n_d = 1'b1;
							state_d = ST_RX;
							phase_d = (phase_q == PH_SEL) ? PH_WORD : PH_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bitcnt_q == 4'd7) begin
							oe_n_d = 1'b1;
							state_d = ST_RACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_n_d = sh_q[6];
							bitcnt_d = bitcnt_q + 4'd1;
						end
					end
				end
				ST_RACK: begin
					// Low bit of the spent shifter holds the host's answer
					if (scl_rise) begin
						sh_d[0] = sda_s;
					end else if (scl_fall) begin
						bitcnt_d = 4'h0;
						if (!sh_q[0]) begin
							sh_d = mem_q[ptr_q];
							oe_n_d = mem_q[ptr_q][7];
							ptr_d = ptr_q + 8'd1;
							state_d = ST_TX;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				default: state_d = state_q;
			endcase
		end
		busy_d = (state_d == ST_PROG);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			phase_q <= PH_SEL;
			rw_q <= 1'b0;
			bitcnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			wcount_q <= 5'd0;
			wrote_q <= 1'b0;
			oe_n_q <= 1'b1;
			busy_q <= 1'b0;
			prog_cnt_q <= '0;
			sync_m_q <= 6'h3F;
			sync_s_q <= 6'h3F;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			for (int i = 0; i < spd_pkg::TABLE_BYTES; i++) begin
				// All 256 locations; 0 to 17 from the table, the rest zero
				mem_q[i] <= spd_pkg::table_reset(8'(i), DENSITY, SPEED_GRADE);
			end
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			rw_q <= rw_d;
			bitcnt_q <= bitcnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			wcount_q <= wcount_d;
			wrote_q <= wrote_d;
			oe_n_q <= oe_n_d;
			busy_q <= busy_d;
			prog_cnt_q <= prog_cnt_d;
			sync_m_q <= {link.scl, link.sda, link.write_inhibit_input,
				module_slot_pin_2, module_slot_pin_1, module_slot_pin_0};
			sync_s_q <= sync_m_q;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
			for (int i = 0; i < spd_pkg::TABLE_BYTES; i++) begin
				mem_q[i] <= mem_d[i];
			end
		end
	end
endmodule

// [dv/spd_link_chk.sv]
module spd_link_chk #(
	parameter int PROG = spd_pkg::PROG_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic write_inhibit_input,
	input wire logic prog_busy
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Bus condition tracking
	// ********
	logic        scl_q;
	logic        sda_q;
	logic        frame_q;
	logic        frame_d;
	logic [3:0]  stop_age_q;
	logic [3:0]  stop_age_d;
	logic [31:0] busy_n_q;
	logic [31:0] busy_n_d;
	logic        start_w;
	logic        stop_w;

	assign start_w = scl && scl_q && sda_q && !sda;
	assign stop_w  = scl && scl_q && !sda_q && sda;

	always_comb begin
		frame_d    = stop_w ? 1'b0 : (start_w ? 1'b1 : frame_q);
		stop_age_d = stop_w ? 4'h0 : stop_age_q + 4'(stop_age_q != 4'hF);
		busy_n_d   = prog_busy ? busy_n_q + 32'h1 : 32'h0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			frame_q    <= 1'b0;
			stop_age_q <= 4'hF;
			busy_n_q   <= 32'h0;
		end else begin
			scl_q      <= scl;
			sda_q      <= sda;
			frame_q    <= frame_d;
			stop_age_q <= stop_age_d;
			busy_n_q   <= busy_n_d;
		end
	end

	// ********
	// Properties
	// ********
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_open_drain: assert property (
		!dev_sda_oe_n |-> !dev_sda_o) else $error("sda driven high");
	a_stable_high: assert property (
		scl && scl_q |-> $stable(dev_sda_oe_n)) else $error("sda moved");
	a_change_late: assert property (
		$changed(dev_sda_oe_n) |-> !scl && !$past(scl, 2))
		else $error("sda change too early");
	a_quiet_idle: assert property (
		!frame_q |-> dev_sda_oe_n) else $error("driven outside frame");
	a_busy_silent: assert property (
		prog_busy |-> dev_sda_oe_n) else $error("driven while busy");
	a_busy_after_stop: assert property (
		$rose(prog_busy) |-> stop_age_q < 4'h8)
		else $error("program without stop");
	a_busy_holds: assert property (
		$rose(prog_busy) |=> prog_busy [*8]) else $error("busy glitch");
	a_busy_bounded: assert property (
		busy_n_q <= PROG + 2) else $error("program too long");
	a_no_prog_inhibit: assert property (
		$rose(prog_busy) |-> !write_inhibit_input)
		else $error("program while inhibited");
endmodule

// [dv/presence_detect_eeprom_slave_tb.sv]
module presence_detect_eeprom_slave_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int PROG  = 600;
	localparam int LIMIT = 60000;

	logic        pclk       = 1'b0;
	logic        presetn    = 1'b0;
	logic        psel       = 1'b0;
	logic        penable    = 1'b0;
	logic        pwrite     = 1'b0;
	logic [7:0]  paddr      = 8'h00;
	logic [31:0] pwdata     = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        prog_busy;
	logic [2:0]  slot       = 3'b101;
	logic [31:0] rd;
	logic        err;
	logic [31:0] st;
	logic [7:0]  mon_first  = 8'h00;
	logic [3:0]  mon_n      = 4'h8;
	logic        mscl_q     = 1'b1;
	logic        msda_q     = 1'b1;
	int          cyc        = 0;
	int          n_tests    = 0;
	int          n_mismatch = 0;
	logic [7:0]  tbl [18]   = '{8'h80, 8'h08, 8'h04, 8'h0D, 8'h09, 8'h02,
		8'h40, 8'h00, 8'h01, 8'h75, 8'h54, 8'h00, 8'h82, 8'h10, 8'h00,
		8'h01, 8'h8F, 8'h04};
	wire  [7:0]  sel_w      = {4'hA, slot, 1'b0};
	wire  [7:0]  sel_r      = {4'hA, slot, 1'b1};

	always #2.5 pclk = ~pclk;

	spd_link_if spd_link_if_i ();
	wire scl = spd_link_if_i.scl;
	wire sda = spd_link_if_i.sda;
	wire wi  = spd_link_if_i.write_inhibit_input;

	spd_host_ctrl #(.QTR(8)) spd_host_ctrl_i (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.link    (spd_link_if_i)
	);
	spd_eeprom_dev #(.PROG_CYCLES(PROG)) spd_eeprom_dev_i (
		.pclk              (pclk),
		.presetn           (presetn),
		.link              (spd_link_if_i),
		.module_slot_pin_0 (slot[0]),
		.module_slot_pin_1 (slot[1]),
		.module_slot_pin_2 (slot[2]),
		.prog_busy         (prog_busy)
	);
	spd_link_chk #(.PROG(PROG)) spd_link_chk_i (
		.pclk                (pclk),
		.presetn             (presetn),
		.scl                 (scl),
		.sda                 (sda),
		.dev_sda_o           (spd_link_if_i.dev_sda_o),
		.dev_sda_oe_n        (spd_link_if_i.dev_sda_oe_n),
		.write_inhibit_input (wi),
		.prog_busy           (prog_busy)
	);

	// ********
	// Wire monitor and hang guard
	// ********
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		mscl_q <= scl;
		msda_q <= sda;
		if (mscl_q && scl && msda_q && !sda) begin
			mon_n <= 4'h0;
		end else if (!mscl_q && scl && mon_n < 4'h8) begin
			mon_n <= mon_n + 4'h1;
			mon_first <= {mon_first[6:0], sda};
		end
		if (cyc == LIMIT) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ********
	// Shared tasks
	// ********
	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Host is polled; no fixed link timing is assumed
	task automatic cmd(input spd_pkg::op_e op, input logic ack,
		input logic [7:0] b);
		apb(1'b1, spd_pkg::CMD_OFS, {16'h0, b, 5'h0, ack, op});
		do apb(1'b0, spd_pkg::STAT_OFS, 32'h0);
		while (rd[spd_pkg::STAT_BUSY_BIT] !== 1'b0);
		st = rd;
	endtask

	task automatic wb(input logic [7:0] b, input logic nack);
		cmd(spd_pkg::OP_WRITE, 1'b0, b);
		chk({7'h0, st[1]}, {7'h0, nack});
	endtask

	task automatic seek(input logic [7:0] a);
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb(sel_w, 1'b0);
		wb(a, 1'b0);
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb(sel_r, 1'b0);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_regs();
		apb(1'b0, spd_pkg::WCTL_OFS, 32'h0);
		chk(rd[7:0], 8'h01);
		chk({7'h0, wi}, 8'h01);
		apb(1'b0, 8'h0C, 32'h0);
		chk({7'h0, err}, 8'h01);
		chk(rd[7:0], 8'h00);
	endtask

	task automatic t_table();
		seek(8'h00);
		chk(mon_first, sel_r);
		for (int i = 0; i < 18; i++) begin
			cmd(spd_pkg::OP_READ, i != 17, 8'h00);
			if (i < 9) chk(st[15:8], tbl[i]);
			else chk(st[15:8], tbl[i]);
		end
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		chk({6'h0, scl, sda}, 8'h03);
	endtask

	task automatic t_inhibit();
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb(sel_w, 1'b0);
		wb(8'h05, 1'b0);
		wb(8'h33, 1'b1);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		chk({7'h0, prog_busy}, 8'h00);
		seek(8'h05);
		cmd(spd_pkg::OP_READ, 1'b0, 8'h00);
		chk(st[15:8], 8'h02);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
	endtask

	task automatic t_page();
		int n;
		apb(1'b1, spd_pkg::WCTL_OFS, 32'h0);
		chk({7'h0, wi}, 8'h00);
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb(sel_w, 1'b0);
		wb(8'hFE, 1'b0);
		for (int i = 0; i < 17; i++) wb(8'hC0 + 8'(i), i == 16);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		chk({7'h0, prog_busy}, 8'h01);
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb(sel_r, 1'b1);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		n = 0;
		while (prog_busy === 1'b1 && n < PROG) begin
			@(posedge pclk);
			n++;
		end
		chk({7'h0, prog_busy}, 8'h00);
		seek(8'hFE);
		for (int i = 0; i < 15; i++) begin
			cmd(spd_pkg::OP_READ, i != 14, 8'h00);
			chk(st[15:8], 8'hC0 + 8'(i));
		end
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb(sel_r, 1'b0);
		cmd(spd_pkg::OP_READ, 1'b1, 8'h00);
		chk(st[15:8], 8'hCF);
		cmd(spd_pkg::OP_READ, 1'b0, 8'h00);
		chk(st[15:8], 8'h00);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
	endtask

	task automatic t_select();
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb({4'hA, ~slot, 1'b1}, 1'b1);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		cmd(spd_pkg::OP_START, 1'b0, 8'h00);
		wb({4'h6, slot, 1'b1}, 1'b1);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
		wb(sel_r, 1'b1);
		cmd(spd_pkg::OP_STOP, 1'b0, 8'h00);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_table();
		t_inhibit();
		t_page();
		t_select();
		print_verdict();
	end
endmodule
